// ===== core/ecc_mark_params.svh
`ifndef ECC_MARK_PARAMS_SVH
`define ECC_MARK_PARAMS_SVH

// ==========================================================================
// Word and check-bit geometry
// ==========================================================================
`define EM_DATA_W        64
`define EM_CHECK_W       8
`define EM_TAG_W         14

// ==========================================================================
// Syndrome of a marked doubleword
// ==========================================================================
`define EM_SYN_MARKED    8'h7F

// ==========================================================================
// Field positions of the marking doubleword
// ==========================================================================
`define EM_TAG_HI_MSB    55
`define EM_TAG_HI_LSB    42
`define EM_TAG_LO_MSB    13
`define EM_TAG_LO_LSB    0

// ==========================================================================
// Mark source tag layout and origin unit codes
// ==========================================================================
`define EM_UNIT_MSB      13
`define EM_UNIT_LSB      12
`define EM_UNIT_MEMORY   2'h0
`define EM_UNIT_CHANNEL  2'h1
`define EM_UNIT_CPU      2'h2
`define EM_DET_ZERO      12'h000
`define EM_DET_CPU_PATH  12'h800
`define EM_DET_L1D_HI    8'h00

// ==========================================================================
// Trap type codes, highest priority first
// ==========================================================================
`define EM_TT_W          9
`define EM_TT_FATAL      9'h001
`define EM_TT_ERR_STATE  9'h002
`define EM_TT_ASYNC      9'h040
`define EM_TT_DATA_ACC   9'h032
`define EM_TT_INSTR_ACC  9'h00A
`define EM_TT_ECC        9'h063
`define EM_TT_NONE       9'h000

// ==========================================================================
// Fault status bit positions
// ==========================================================================
`define EM_STAT_W        3
`define EM_STAT_CE       0
`define EM_STAT_UE_RAW   1
`define EM_STAT_UE_MARK  2

`endif

// ===== core/ecc_mark_pkg.sv
// ==========================================================================
// Types shared by the error marking logic
// ==========================================================================
package ecc_mark_pkg;

  // Where the checked doubleword came from
  typedef enum logic [2:0] {
    LOC_MEM_IN  = 3'h0,  // Incoming from main memory or its bus
    LOC_MEM_OUT = 3'h1,  // Outgoing to memory
    LOC_L2      = 3'h2,  // Second-level cache data
    LOC_L1D     = 3'h3,  // First-level data cache data
    LOC_INTR    = 3'h4,  // Received interrupt payload
    LOC_OTHER   = 3'h5   // Other ECC-protected storage
  } loc_type;

  // Selected trap class, one-hot
  typedef enum logic [6:0] {
    TC_NONE      = 7'h01,
    TC_FATAL     = 7'h02,
    TC_ERR_STATE = 7'h04,
    TC_ASYNC     = 7'h08,
    TC_DATA_ACC  = 7'h10,
    TC_INSTR_ACC = 7'h20,
    TC_ECC       = 7'h40
  } trap_class_type;

endpackage : ecc_mark_pkg

// ===== core/secded_codec.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Single-correct double-detect codec, odd-weight columns
// ==========================================================================
module secded_codec #(
  parameter int DATA_W  = 64,
  parameter int CHECK_W = 8
) (
  input  wire logic [DATA_W-1:0]  i_data,     // Data as stored
  input  wire logic [CHECK_W-1:0] i_check,    // Check bits as stored
  output logic      [CHECK_W-1:0] o_gen_check,// Fresh check bits of i_data
  output logic      [CHECK_W-1:0] o_syndrome, // Stored xor fresh
  output logic      [DATA_W-1:0]  o_corrected,// Data with single bit fixed
  output logic                    o_single,   // Correctable error
  output logic                    o_multi     // Uncorrectable error
);

  // Column table only covers eight check bits and 64 data bits
  if (CHECK_W != 8 || DATA_W < 1 || DATA_W > 64)
  begin : g_bad_size
    $error("secded_codec: unsupported width");
  end

  // Idx-th code of weight three, then weight five
  function automatic logic [CHECK_W-1:0] column(input int idx);
    int n;
    n = 0;
    column = '0;
    for (int w = 3; w <= 5; w += 2)
    begin
      for (int v = 0; v < (1 << CHECK_W); v++)
      begin
        if ($countones(v[CHECK_W-1:0]) == w)
        begin
          if (n == idx)
            column = v[CHECK_W-1:0];
          n++;
        end
      end
    end
  endfunction : column

  logic [DATA_W-1:0] flip;   // Bit whose column matches the syndrome

  // Check bit generation
  always_comb
  begin
    o_gen_check = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (i_data[i])
        o_gen_check = o_gen_check ^ column(i);
    end
  end

  assign o_syndrome = o_gen_check ^ i_check;

  // Per-bit syndrome match
  for (genvar g = 0; g < DATA_W; g++)
  begin : g_bit
    assign flip[g] = (o_syndrome == column(g));
  end

  assign o_corrected = i_data ^ flip;
  // Weight one means a check bit flipped: data already good
  assign o_single = (|flip) || ($countones(o_syndrome) == 1);
  assign o_multi  = (o_syndrome != '0) && !o_single;

endmodule : secded_codec

`default_nettype wire

// ===== core/ecc_error_marking_and_priority.sv
// Summary of operation
// - Trap priority fatal, state, async, data, instr, ECC
// - Correctable error: deliver corrected data, no stall
// - Write back corrected data except memory, interrupt
// - Marking covers memory, bus, L2, L1D data
// - Unmarked uncorrectable word on those paths replaced by marking pattern
// - Syndrome 7F marked; other multi-bit is raw
// - Tag in 55:42 and 13:0, others zero
// - Marking check bits yield syndrome 7F later
// - Tag bits 13:12 name originating unit
// - Memory unit gives zero detector field, else detector
// - Report an uncorrectable error only once for memory, bus, L2, L1D
// - L1D marking takes identity register low nibble
`timescale 1ns/100ps
`default_nettype none
`include "ecc_mark_params.svh"

module ecc_error_marking_and_priority
  import ecc_mark_pkg::*;
#(
  parameter int DATA_W  = `EM_DATA_W,
  parameter int CHECK_W = `EM_CHECK_W
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_word_valid,
  input  wire logic [DATA_W-1:0]  i_word_data,
  input  wire logic [CHECK_W-1:0] i_word_check,
  input  wire loc_type            i_word_loc,
  input  wire logic [3:0]         i_eidr_id,
  input  wire logic               i_fatal_err,
  input  wire logic               i_err_state_err,
  input  wire logic               i_async_data_err,
  input  wire logic               i_data_access_err,
  input  wire logic               i_instr_access_err,
  input  wire logic [`EM_STAT_W-1:0] i_status_clear,
  output logic                    o_word_valid,
  output logic [DATA_W-1:0]       o_word_data,
  output logic [CHECK_W-1:0]      o_word_check,
  output logic                    o_ce,
  output logic                    o_ue_raw,
  output logic                    o_ue_marked,
  output logic                    o_wb_valid,
  output logic [DATA_W-1:0]       o_wb_data,
  output logic [CHECK_W-1:0]      o_wb_check,
  output logic [`EM_TAG_W-1:0]    o_mark_source_tag,
  output logic [`EM_STAT_W-1:0]   o_async_fault_status,
  output logic                    o_trap_valid,
  output logic [`EM_TT_W-1:0]     o_trap_type
);

  // Marking layout is fixed to a 64-bit doubleword
  if (DATA_W != 64 || CHECK_W != 8)
  begin : g_bad_size
    $error("ecc_error_marking_and_priority: needs 64 data, 8 check");
  end

  // ========================================================================
  // Check of the incoming doubleword
  // ========================================================================
  logic [CHECK_W-1:0] in_gen;       // Fresh check bits of incoming data
  logic [CHECK_W-1:0] in_syn;       // Syndrome of the incoming word
  logic [DATA_W-1:0]  in_fixed;     // Corrected data
  logic               in_single;    // Correctable
  logic               in_multi;     // Uncorrectable or marked

  // Same code as normal data path
  secded_codec #(.DATA_W(DATA_W), .CHECK_W(CHECK_W)) u_check (
    .i_data      (i_word_data),
    .i_check     (i_word_check),
    .o_gen_check (in_gen),
    .o_syndrome  (in_syn),
    .o_corrected (in_fixed),
    .o_single    (in_single),
    .o_multi     (in_multi)
  );

  logic det_ce;        // Correctable this cycle
  logic det_marked;    // Already marked word
  logic det_raw;       // Raw uncorrectable word
  logic cacheable;     // Location is on a marked path

  assign det_ce     = i_word_valid && in_single;
  // Syndrome 7F alone means marked
  assign det_marked = i_word_valid && (in_syn == `EM_SYN_MARKED);
  assign det_raw    = i_word_valid && in_multi && !det_marked;

  // Memory, its bus, L2 and L1D carry marking
  assign cacheable = (i_word_loc == LOC_MEM_IN)  ||
                     (i_word_loc == LOC_MEM_OUT) ||
                     (i_word_loc == LOC_L2)      ||
                     (i_word_loc == LOC_L1D);

  // ========================================================================
  // Mark source tag and marking doubleword
  // ========================================================================
  logic [`EM_TAG_W-1:0] next_tag;   // Tag for this word's location
  logic [DATA_W-1:0]    mark_data;  // Marking data, error bits zero
  logic [CHECK_W-1:0]   mark_gen;   // Plain check bits of mark_data
  logic [CHECK_W-1:0]   mark_check; // Check bits forcing syndrome 7F

  // Unit code in the top bits, detector below
  always_comb
  begin
    case (i_word_loc)
      LOC_MEM_IN:  next_tag = {`EM_UNIT_MEMORY, `EM_DET_ZERO};
      LOC_L1D:     next_tag = {`EM_UNIT_CPU, `EM_DET_L1D_HI,
                               i_eidr_id};
      default:     next_tag = {`EM_UNIT_CPU, `EM_DET_CPU_PATH};
    endcase
  end

  // Zero fields everywhere but the two tag copies
  always_comb
  begin
    mark_data = '0;
    mark_data[`EM_TAG_HI_MSB:`EM_TAG_HI_LSB] = next_tag;
    mark_data[`EM_TAG_LO_MSB:`EM_TAG_LO_LSB] = next_tag;
  end

  secded_codec #(.DATA_W(DATA_W), .CHECK_W(CHECK_W)) u_mark (
    .i_data      (mark_data),
    .i_check     ('0),
    .o_gen_check (mark_gen),
    .o_syndrome  (),
    .o_corrected (),
    .o_single    (),
    .o_multi     ()
  );

  // Inverting the syndrome bits makes any recheck see 7F
  assign mark_check = mark_gen ^ `EM_SYN_MARKED;

  // ========================================================================
  // Delivered word and error flags
  // ========================================================================
  // One register stage, no stall on any error class
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_word_valid <= 1'b0;
      o_word_data  <= '0;
      o_word_check <= '0;
      o_ce         <= 1'b0;
      o_ue_raw     <= 1'b0;
      o_ue_marked  <= 1'b0;
      o_mark_source_tag <= '0;
    end
    else
    begin
      o_word_valid <= i_word_valid;
      o_ce         <= det_ce;
      o_ue_raw     <= det_raw;
      o_ue_marked  <= det_marked;
      o_mark_source_tag <= next_tag;
      if (det_raw && cacheable)
      begin
        // Raw word replaced before anyone consumes it
        o_word_data  <= mark_data;
        o_word_check <= mark_check;
      end
      else if (det_ce)
      begin
        // Consumer always gets fixed data
        o_word_data  <= in_fixed;
        o_word_check <= in_fixed == i_word_data ? i_word_check
                                                : in_gen ^ in_syn;
      end
      else
      begin
        // Marked words pass untouched, never re-marked
        o_word_data  <= i_word_data;
        o_word_check <= i_word_check;
      end
    end
  end

  // ========================================================================
  // Write back to the source
  // ========================================================================
  logic ce_fixable;   // Source may be repaired by hardware

  // Memory and interrupt payload are left for software
  assign ce_fixable = (i_word_loc != LOC_MEM_IN) &&
                      (i_word_loc != LOC_INTR);

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_wb_valid <= 1'b0;
      o_wb_data  <= '0;
      o_wb_check <= '0;
    end
    else if (det_raw && cacheable)
    begin
      o_wb_valid <= 1'b1;
      o_wb_data  <= mark_data;
      o_wb_check <= mark_check;
    end
    else if (det_ce && ce_fixable)
    begin
      o_wb_valid <= 1'b1;
      o_wb_data  <= in_fixed;
      // Source gets check bits that match the repaired data exactly
      o_wb_check <= (in_fixed == i_word_data) ? in_gen : in_gen ^ in_syn;
    end
    else
    begin
      o_wb_valid <= 1'b0;
    end
  end

  // ========================================================================
  // Fault status accumulation
  // ========================================================================
  logic [`EM_STAT_W-1:0] stat_set;  // Events of this cycle

  assign stat_set[`EM_STAT_CE]      = det_ce;
  assign stat_set[`EM_STAT_UE_RAW]  = det_raw;
  assign stat_set[`EM_STAT_UE_MARK] = det_marked;

  // Sticky bits, a new event beats a clear
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      o_async_fault_status <= '0;
    else
      o_async_fault_status <= stat_set |
                              (o_async_fault_status & ~i_status_clear);
  end

  // ========================================================================
  // Trap selection
  // ========================================================================
  trap_class_type next_class;  // Winning class this cycle

  // Fixed priority order
  always_comb
  begin
    if (i_fatal_err)
      next_class = TC_FATAL;
    else if (i_err_state_err)
      next_class = TC_ERR_STATE;
    else if (i_async_data_err)
      next_class = TC_ASYNC;
    else if (i_data_access_err)
      next_class = TC_DATA_ACC;
    else if (i_instr_access_err)
      next_class = TC_INSTR_ACC;
    else if (det_raw)
      next_class = TC_ECC;  // Marked words raise nothing
    else
      next_class = TC_NONE;
  end

  // Registered trap code, same latency as the word
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_trap_valid <= 1'b0;
      o_trap_type  <= `EM_TT_NONE;
    end
    else
    begin
      o_trap_valid <= (next_class != TC_NONE);
      case (next_class)
        TC_FATAL:     o_trap_type <= `EM_TT_FATAL;
        TC_ERR_STATE: o_trap_type <= `EM_TT_ERR_STATE;
        TC_ASYNC:     o_trap_type <= `EM_TT_ASYNC;
        TC_DATA_ACC:  o_trap_type <= `EM_TT_DATA_ACC;
        TC_INSTR_ACC: o_trap_type <= `EM_TT_INSTR_ACC;
        TC_ECC:       o_trap_type <= `EM_TT_ECC;
        default:      o_trap_type <= `EM_TT_NONE;
      endcase
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  loc_type r_loc;   // Location of the word now on the outputs

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      r_loc <= LOC_OTHER;
    else
      r_loc <= i_word_loc;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_trap_fatal_wins: assert property (
    i_fatal_err |=> o_trap_valid && o_trap_type == 9'h001)
    else $error("fatal error did not win trap priority");
  a_trap_async_order: assert property (
    !i_fatal_err && !i_err_state_err && i_async_data_err
    |=> o_trap_type == 9'h040)
    else $error("async data error trap code wrong");
  a_trap_ecc_last: assert property (
    det_raw && !i_fatal_err && !i_err_state_err && !i_async_data_err &&
    !i_data_access_err && !i_instr_access_err |=> o_trap_type == 9'h063)
    else $error("ECC trap code wrong");
  a_status_sticky: assert property (
    o_async_fault_status[0] && !i_status_clear[0]
    |=> o_async_fault_status[0])
    else $error("fault status bit lost");
  a_ce_delivers: assert property (
    det_ce |=> o_word_valid && o_ce && o_word_data == $past(in_fixed))
    else $error("corrected data not delivered");
  a_wb_skip_source: assert property (
    o_wb_valid && o_ce |-> r_loc != LOC_MEM_IN && r_loc != LOC_INTR)
    else $error("memory or interrupt copy written back");
  a_mark_layout: assert property (
    o_wb_valid && o_ue_raw |-> o_wb_data[55:42] == o_wb_data[13:0] &&
    o_wb_data[62:56] == 7'h00 && o_wb_data[41:36] == 6'h00 &&
    o_wb_data[34:23] == 12'h000 && o_wb_data[21:14] == 8'h00)
    else $error("marking pattern layout wrong");
  a_mark_mem_zero: assert property (
    o_ue_raw && r_loc == LOC_MEM_IN |-> o_wb_data[13:0] == 14'h0000)
    else $error("memory unit tag not zero");
  a_mark_l1d_id: assert property (
    o_ue_raw && r_loc == LOC_L1D
    |-> o_wb_data[13:0] == {2'h2, 8'h00, $past(i_eidr_id)})
    else $error("L1D tag does not carry identity nibble");
  a_marked_once: assert property (
    det_marked |=> !o_ue_raw && !o_wb_valid && o_trap_type != 9'h063)
    else $error("marked word reported again");

  c_raw_marked: cover property (det_raw && cacheable ##1 o_wb_valid);
  c_ce_fixed:   cover property (det_ce && ce_fixable ##1 o_wb_valid);
  c_marked_in:  cover property (det_marked);
  c_fatal_ecc:  cover property (i_fatal_err && det_raw);

endmodule : ecc_error_marking_and_priority

`default_nettype wire

// ===== core/HANDOVER_unused_placeholder_never.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== verif/mem_path_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Check-bit encoder for the bench, written apart from the design's codec
// ==========================================================================
package ecc_model_pkg;

  // Column of data bit idx: weight-3 bytes ascending, then weight-5 bytes
  function automatic logic [7:0] col_of(input int idx);
    int n;
    n = 0;
    col_of = 8'h00;
    for (int w = 3; w <= 5; w += 2)
      for (int v = 0; v < 256; v++)
        if ($countones(v) == w)
        begin
          if (n == idx)
            col_of = 8'(v);
          n++;
        end
  endfunction : col_of

  // Fresh check bits of a doubleword
  function automatic logic [7:0] gen_check(input logic [63:0] d);
    gen_check = 8'h00;
    for (int i = 0; i < 64; i++)
      if (d[i])
        gen_check = gen_check ^ col_of(i);
  endfunction : gen_check

endpackage : ecc_model_pkg

// ==========================================================================
// Cache or memory datapath that hands stored words to the checker
// ==========================================================================
module mem_path_model
  import ecc_mark_pkg::*;
  import ecc_model_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_req_valid,  // Word requested this cycle
  input  wire logic [63:0] i_req_data,   // Clean data before injection
  input  wire logic [1:0]  i_req_kind,   // 0 clean 1 CE 2 raw UE 3 marked
  input  wire logic [5:0]  i_req_a,      // First flipped bit
  input  wire logic [5:0]  i_req_b,      // Second flipped bit, differs
  input  wire loc_type     i_req_loc,    // Storage the word came from
  output logic             o_word_valid,
  output logic [63:0]      o_word_data,
  output logic [7:0]       o_word_check,
  output loc_type          o_word_loc
);
  logic [63:0] last_data = 64'h0;  // Last word, scrambled while idle

  // ========================================================================
  // Error injection; idle bus shows the inverse, never a stale copy
  // ========================================================================
  always_comb
  begin
    o_word_valid = i_req_valid;
    o_word_loc   = i_req_loc;
    o_word_data  = i_req_data;
    o_word_check = gen_check(i_req_data);
    case (i_req_kind)
      2'h1: o_word_data = i_req_data ^ (64'h1 << i_req_a);
      2'h2: o_word_data = i_req_data ^ (64'h1 << i_req_a) ^ (64'h1 << i_req_b);
      2'h3: o_word_check = o_word_check ^ 8'h7F;
      default: ;
    endcase
    if (!i_req_valid)
    begin
      o_word_data  = ~last_data;
      o_word_check = ~o_word_check;
    end
  end

  // Remember the last presented word
  always @(posedge i_clk)
    if (i_req_valid)
      last_data <= o_word_data;

endmodule : mem_path_model

`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ecc_mark_params.svh"

module tb import ecc_mark_pkg::*, ecc_model_pkg::*;;

  // Expected result of one presented word
  typedef struct {
    logic ce, raw, mk, wb, trapv;
    logic [63:0] data, wbd;
    logic [7:0] chk, wbc;
    logic [13:0] tag;
    logic [8:0] tt;
  } expect_type;

  logic clk, rst_n, req_valid, o_word_valid, o_ce, o_ue_raw, o_ue_marked;
  logic o_wb_valid, o_trap_valid, w_valid;
  logic [63:0] req_data, w_data, o_word_data, o_wb_data;
  logic [7:0] w_check, o_word_check, o_wb_check;
  logic [1:0] req_kind;
  logic [5:0] req_a, req_b;
  logic [3:0] eidr;
  logic [4:0] err;                  // fatal, state, async, data, instr
  logic [2:0] status_clear, o_async_fault_status;
  logic [13:0] o_mark_source_tag;
  logic [8:0] o_trap_type;
  loc_type req_loc, w_loc;
  expect_type notes[$];             // Expectations, oldest first
  expect_type seen;
  int failures, num_checks, seed_dummy;

  mem_path_model mem_path_model_i (.i_clk(clk), .i_req_valid(req_valid),
    .i_req_data(req_data), .i_req_kind(req_kind), .i_req_a(req_a),
    .i_req_b(req_b), .i_req_loc(req_loc), .o_word_valid(w_valid),
    .o_word_data(w_data), .o_word_check(w_check), .o_word_loc(w_loc));

  ecc_error_marking_and_priority ecc_error_marking_and_priority_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_word_valid(w_valid),
    .i_word_data(w_data), .i_word_check(w_check), .i_word_loc(w_loc),
    .i_eidr_id(eidr), .i_fatal_err(err[0]), .i_err_state_err(err[1]),
    .i_async_data_err(err[2]), .i_data_access_err(err[3]),
    .i_instr_access_err(err[4]), .i_status_clear(status_clear),
    .o_word_valid(o_word_valid), .o_word_data(o_word_data),
    .o_word_check(o_word_check), .o_ce(o_ce), .o_ue_raw(o_ue_raw),
    .o_ue_marked(o_ue_marked), .o_wb_valid(o_wb_valid),
    .o_wb_data(o_wb_data), .o_wb_check(o_wb_check),
    .o_mark_source_tag(o_mark_source_tag),
    .o_async_fault_status(o_async_fault_status),
    .o_trap_valid(o_trap_valid), .o_trap_type(o_trap_type));

  // ========================================================================
  // Comparison and verdict
  // ========================================================================
  task automatic cmp_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_vec(input string what, input logic [63:0] e,
                         input logic [63:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_vec

  task automatic conclude();
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // Highest pending trap class wins
  function automatic logic [8:0] prio(input logic [4:0] e, input logic raw);
    return e[0] ? `EM_TT_FATAL : e[1] ? `EM_TT_ERR_STATE :
           e[2] ? `EM_TT_ASYNC : e[3] ? `EM_TT_DATA_ACC :
           e[4] ? `EM_TT_INSTR_ACC : raw ? `EM_TT_ECC : `EM_TT_NONE;
  endfunction : prio

  // ========================================================================
  // Driver: present one word, note what must come out a cycle later
  // ========================================================================
  task automatic send(input logic [1:0] kind, input loc_type loc,
                      input logic [4:0] e);
    expect_type x;
    logic [63:0] d, dr, mark;
    logic [13:0] tag;
    logic marks;
    int ia, ib;
    d = {$urandom, $urandom};
    ia = $urandom % 64;
    ib = (ia + 1 + $urandom % 63) % 64;
    eidr = 4'($urandom);
    dr = d ^ (64'h1 << ia) ^ (64'h1 << ib);
    marks = loc inside {LOC_MEM_IN, LOC_MEM_OUT, LOC_L2, LOC_L1D};
    if (loc == LOC_MEM_IN)
      tag = {`EM_UNIT_MEMORY, `EM_DET_ZERO};
    else if (loc == LOC_L1D)
      tag = {`EM_UNIT_CPU, `EM_DET_L1D_HI, eidr};
    else
      tag = {`EM_UNIT_CPU, `EM_DET_CPU_PATH};
    mark = 64'h0;
    mark[55:42] = tag;
    mark[13:0] = tag;
    x.ce = kind == 2'h1;
    x.raw = kind == 2'h2;
    x.mk = kind == 2'h3;
    x.data = (x.raw && marks) ? mark : x.raw ? dr : d;
    x.chk = (x.raw && marks) ? gen_check(mark) ^ 8'h7F :
            x.mk ? gen_check(d) ^ 8'h7F : gen_check(d);
    x.wb = (x.ce && !(loc inside {LOC_MEM_IN, LOC_INTR})) || (x.raw && marks);
    x.wbd = x.ce ? d : mark;
    x.wbc = x.ce ? gen_check(d) : gen_check(mark) ^ 8'h7F;
    x.tag = tag;
    x.tt = prio(e, x.raw);
    x.trapv = (|e) || x.raw;
    req_valid = 1'b1;
    req_data = d;
    req_kind = kind;
    req_a = 6'(ia);
    req_b = 6'(ib);
    req_loc = loc;
    err = e;
    notes.push_back(x);
    @(posedge clk);
    #2;
  endtask : send

  // Bus released for a number of cycles
  task automatic idle(input int n);
    req_valid = 1'b0;
    err = 5'h00;
    repeat (n) @(posedge clk);
    #2;
  endtask : idle

  // ========================================================================
  // Monitor: settled outputs checked at the falling edge
  // ========================================================================
  always @(negedge clk)
    if (rst_n === 1'b1)
    begin
      if (o_word_valid === 1'b1 && notes.size() > 0)
      begin
        seen = notes.pop_front();
        cmp_bit("ce", seen.ce, o_ce);
        cmp_bit("ue_raw", seen.raw, o_ue_raw);
        cmp_bit("ue_marked", seen.mk, o_ue_marked);
        cmp_vec("data", seen.data, o_word_data);
        cmp_vec("check", {56'h0, seen.chk}, {56'h0, o_word_check});
        cmp_bit("wb_valid", seen.wb, o_wb_valid);
        if (seen.wb)
        begin
          cmp_vec("wb_data", seen.wbd, o_wb_data);
          cmp_vec("wb_check", {56'h0, seen.wbc}, {56'h0, o_wb_check});
        end
        cmp_vec("tag", {50'h0, seen.tag}, {50'h0, o_mark_source_tag});
        cmp_bit("trap_valid", seen.trapv, o_trap_valid);
        cmp_vec("trap_type", {55'h0, seen.tt}, {55'h0, o_trap_type});
      end
      else
      begin
        cmp_bit("word_valid", 1'b0, o_word_valid);
        cmp_bit("trap_valid", 1'b0, o_trap_valid);
      end
    end

  // Clock and watchdog; the run needs well under a thousand cycles
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    conclude();
  end

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_data = 64'h0;
    req_kind = 2'h0;
    req_a = 6'h00;
    req_b = 6'h01;
    req_loc = LOC_MEM_IN;
    eidr = 4'h0;
    err = 5'h00;
    status_clear = 3'h0;
    seed_dummy = $urandom(38679);
    repeat (12) @(posedge clk);
    #2;
    rst_n = 1'b1;
    idle(1);
    // Every kind at every location, back to back
    for (int k = 0; k < 4; k++)
      for (int l = 0; l < 6; l++)
        send(2'(k), loc_type'(l), 5'h00);
    // Every mix of trap causes against a raw error
    for (int v = 0; v < 32; v++)
      send(2'h2, LOC_L2, 5'(v));
    idle(2);
    cmp_vec("status", 64'h7, {61'h0, o_async_fault_status});
    status_clear = 3'h7;
    @(posedge clk);
    #2;
    status_clear = 3'h0;
    idle(2);
    cmp_vec("status", 64'h0, {61'h0, o_async_fault_status});
    send(2'h2, LOC_OTHER, 5'h00);
    send(2'h1, LOC_INTR, 5'h00);
    idle(2);
    cmp_vec("status", 64'h3, {61'h0, o_async_fault_status});
    status_clear = 3'h1;
    idle(1);
    status_clear = 3'h0;
    idle(1);
    cmp_vec("status", 64'h2, {61'h0, o_async_fault_status});
    // Random traffic with gaps and stray trap causes
    for (int i = 0; i < 300; i++)
    begin
      if ($urandom % 5 == 0)
        idle(1);
      send(2'($urandom), loc_type'($urandom % 6),
           ($urandom % 4 == 0) ? 5'($urandom) : 5'h00);
    end
    idle(3);
    conclude();
  end

endmodule : tb

`default_nettype wire
